/* src/svr_defines.svh */
// Encoding, geometry and round constants of the SM4 vector round unit.
`ifndef SVR_DEFINES_SVH
`define SVR_DEFINES_SVH

`define SVR_MAJOR_OPC 7'h77
`define SVR_FUNCT3_MVV 3'h2
`define SVR_FUNCT6_VV 6'h28
`define SVR_FUNCT6_VS 6'h29
`define SVR_VS1_SM4 5'h10
`define SVR_GROUP_BITS 20'h0_0080
`define SVR_SEW_BITS 7'h20
`define SVR_GROUP_SHIFT 2
`define SVR_LAST_ROUND 2'h3
`define SVR_ROT_A 5'h02
`define SVR_ROT_B 5'h0a
`define SVR_ROT_C 5'h12
`define SVR_ROT_D 5'h18

`endif

/* src/svr_pkg.sv */
// Types and shared helper functions of the SM4 vector round unit.
package svr_pkg;

  typedef enum logic [2:0] {
    SVR_IDLE = 3'b000,
    SVR_LOAD = 3'b001,
    SVR_CAPT = 3'b010,
    SVR_ROUND = 3'b011,
    SVR_NEXT = 3'b100
  } svr_state_e;

  typedef logic [3:0][31:0] svr_quad_t;

  // Rotates a word left by the given number of bit positions.
  function automatic logic [31:0] svr_rol(input logic [31:0] w, input logic [4:0] n);
    svr_rol = (w << n) | (w >> (6'd32 - {1'b0, n}));
  endfunction

endpackage

/* src/svr_round_word.sv */
// One SM4 round word: byte substitution followed by the linear mix.
`timescale 1ns/10ps
`include "svr_defines.svh"

module svr_round_word
  import svr_pkg::*;
(
  input wire logic [31:0] oldest_i,
  input wire logic [31:0] mix_i,
  output logic [31:0] sub_o,
  output logic [31:0] word_o
);

  localparam logic [0:255][7:0] SBOX = {
    8'hd6, 8'h90, 8'he9, 8'hfe, 8'hcc, 8'he1, 8'h3d, 8'hb7, 8'h16, 8'hb6, 8'h14, 8'hc2,
    8'h28, 8'hfb, 8'h2c, 8'h05, 8'h2b, 8'h67, 8'h9a, 8'h76, 8'h2a, 8'hbe, 8'h04, 8'hc3,
    8'haa, 8'h44, 8'h13, 8'h26, 8'h49, 8'h86, 8'h06, 8'h99, 8'h9c, 8'h42, 8'h50, 8'hf4,
    8'h91, 8'hef, 8'h98, 8'h7a, 8'h33, 8'h54, 8'h0b, 8'h43, 8'hed, 8'hcf, 8'hac, 8'h62,
    8'he4, 8'hb3, 8'h1c, 8'ha9, 8'hc9, 8'h08, 8'he8, 8'h95, 8'h80, 8'hdf, 8'h94, 8'hfa,
    8'h75, 8'h8f, 8'h3f, 8'ha6, 8'h47, 8'h07, 8'ha7, 8'hfc, 8'hf3, 8'h73, 8'h17, 8'hba,
    8'h83, 8'h59, 8'h3c, 8'h19, 8'he6, 8'h85, 8'h4f, 8'ha8, 8'h68, 8'h6b, 8'h81, 8'hb2,
    8'h71, 8'h64, 8'hda, 8'h8b, 8'hf8, 8'heb, 8'h0f, 8'h4b, 8'h70, 8'h56, 8'h9d, 8'h35,
    8'h1e, 8'h24, 8'h0e, 8'h5e, 8'h63, 8'h58, 8'hd1, 8'ha2, 8'h25, 8'h22, 8'h7c, 8'h3b,
    8'h01, 8'h21, 8'h78, 8'h87, 8'hd4, 8'h00, 8'h46, 8'h57, 8'h9f, 8'hd3, 8'h27, 8'h52,
    8'h4c, 8'h36, 8'h02, 8'he7, 8'ha0, 8'hc4, 8'hc8, 8'h9e, 8'hea, 8'hbf, 8'h8a, 8'hd2,
    8'h40, 8'hc7, 8'h38, 8'hb5, 8'ha3, 8'hf7, 8'hf2, 8'hce, 8'hf9, 8'h61, 8'h15, 8'ha1,
    8'he0, 8'hae, 8'h5d, 8'ha4, 8'h9b, 8'h34, 8'h1a, 8'h55, 8'had, 8'h93, 8'h32, 8'h30,
    8'hf5, 8'h8c, 8'hb1, 8'he3, 8'h1d, 8'hf6, 8'he2, 8'h2e, 8'h82, 8'h66, 8'hca, 8'h60,
    8'hc0, 8'h29, 8'h23, 8'hab, 8'h0d, 8'h53, 8'h4e, 8'h6f, 8'hd5, 8'hdb, 8'h37, 8'h45,
    8'hde, 8'hfd, 8'h8e, 8'h2f, 8'h03, 8'hff, 8'h6a, 8'h72, 8'h6d, 8'h6c, 8'h5b, 8'h51,
    8'h8d, 8'h1b, 8'haf, 8'h92, 8'hbb, 8'hdd, 8'hbc, 8'h7f, 8'h11, 8'hd9, 8'h5c, 8'h41,
    8'h1f, 8'h10, 8'h5a, 8'hd8, 8'h0a, 8'hc1, 8'h31, 8'h88, 8'ha5, 8'hcd, 8'h7b, 8'hbd,
    8'h2d, 8'h74, 8'hd0, 8'h12, 8'hb8, 8'he5, 8'hb4, 8'hb0, 8'h89, 8'h69, 8'h97, 8'h4a,
    8'h0c, 8'h96, 8'h77, 8'h7e, 8'h65, 8'hb9, 8'hf1, 8'h09, 8'hc5, 8'h6e, 8'hc6, 8'h84,
    8'h18, 8'hf0, 8'h7d, 8'hec, 8'h3a, 8'hdc, 8'h4d, 8'h20, 8'h79, 8'hee, 8'h5f, 8'h3e,
    8'hd7, 8'hcb, 8'h39, 8'h48
  };

  // Each of the four bytes is looked up on its own.
  always_comb
  begin
    for (int b = 0; b < 4; b++)
    begin
      sub_o[b*8 +: 8] = SBOX[mix_i[b*8 +: 8]];
    end
  end

  assign word_o = oldest_i ^ sub_o ^ svr_rol(sub_o, `SVR_ROT_A) ^ svr_rol(sub_o, `SVR_ROT_B)
                  ^ svr_rol(sub_o, `SVR_ROT_C) ^ svr_rol(sub_o, `SVR_ROT_D);

endmodule

/* src/svr_sm4_round_unit.sv */
// SM4 vector round unit: decode, legality checks, group walk and four chained rounds.
`timescale 1ns/10ps
`include "svr_defines.svh"

module svr_sm4_round_unit
  import svr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic instr_valid_i,
  input wire logic [6:0] major_opcode_i,
  input wire logic [2:0] funct3_i,
  input wire logic [5:0] funct6_i,
  input wire logic [4:0] vs1_field_i,
  input wire logic [4:0] vd_i,
  input wire logic [4:0] vs2_i,
  input wire logic [2:0] register_group_multiplier_i,
  input wire logic [15:0] vector_register_bits_i,
  input wire logic [6:0] selected_element_width_i,
  input wire logic [15:0] vector_length_i,
  input wire logic [15:0] start_index_i,
  input wire logic [127:0] state_group_i,
  input wire logic [127:0] key_group_i,
  output logic busy_o,
  output logic rd_req_o,
  output logic [13:0] state_group_o,
  output logic [13:0] key_group_o,
  output logic wr_en_o,
  output logic [13:0] wr_group_o,
  output logic [127:0] wr_data_o,
  output logic done_o,
  output logic fail_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // True when the register group holds at least one 128-bit element group.
  function automatic logic group_fits(input logic [15:0] vector_register_bits, input logic [2:0] mul);
    logic [22:0] prod;
    prod = '0;
    if (!mul[2])
    begin
      prod = {7'h00, vector_register_bits} << mul[1:0];
    end
    else
    begin
      prod = {7'h00, vector_register_bits} >> (3'(-mul));
    end
    group_fits = prod >= 23'({3'h0, `SVR_GROUP_BITS});
  endfunction

  // Number of registers one group spans, at least one.
  function automatic logic [5:0] group_regs(input logic [2:0] mul);
    group_regs = mul[2] ? 6'h01 : 6'(6'h01 << mul[1:0]);
  endfunction

  // True when two register groups of the given span share a register.
  function automatic logic groups_overlap(input logic [4:0] a, input logic [4:0] b,
                                          input logic [5:0] n);
    groups_overlap = ({1'b0, a} < ({1'b0, b} + n)) && ({1'b0, b} < ({1'b0, a} + n));
  endfunction

  logic hit;
  logic is_vs;
  logic illegal;
  logic [13:0] start_grp;
  logic [13:0] len_grp;

  assign is_vs = funct6_i == `SVR_FUNCT6_VS;
  assign hit = instr_valid_i && (major_opcode_i == `SVR_MAJOR_OPC)
               && (funct3_i == `SVR_FUNCT3_MVV)
               && ((funct6_i == `SVR_FUNCT6_VV) || is_vs)
               && (vs1_field_i == `SVR_VS1_SM4);
  assign illegal = !group_fits(vector_register_bits_i, register_group_multiplier_i)
                   || (selected_element_width_i != `SVR_SEW_BITS)
                   || (is_vs && groups_overlap(vd_i, vs2_i,
                                                group_regs(register_group_multiplier_i)));
  assign start_grp = start_index_i[15:`SVR_GROUP_SHIFT];
  assign len_grp = vector_length_i[15:`SVR_GROUP_SHIFT];

  ////////////////////////////////////////////////////////////////////////////////
  // Round datapath.

  svr_state_e st_q, st_d;
  logic [13:0] grp_q, grp_d;
  logic [13:0] end_q, end_d;
  logic [13:0] key_q, key_d;
  logic vs_q, vs_d;
  logic [1:0] cnt_q, cnt_d;
  svr_quad_t x_q, x_d;
  svr_quad_t rk_q, rk_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic [13:0] wrg_q, wrg_d;
  logic [127:0] wdata_q, wdata_d;
  logic done_q, done_d;
  logic fail_q, fail_d;
  logic busy_q, busy_d;
  logic [31:0] mix_w;
  logic [31:0] sub_w;
  logic [31:0] new_w;

  assign mix_w = x_q[1] ^ x_q[2] ^ x_q[3] ^ rk_q[cnt_q];

  svr_round_word u_round (
    .oldest_i(x_q[0]),
    .mix_i(mix_w),
    .sub_o(sub_w),
    .word_o(new_w)
  );

  always_comb
  begin
    st_d = st_q;
    grp_d = grp_q;
    end_d = end_q;
    key_d = key_q;
    vs_d = vs_q;
    cnt_d = cnt_q;
    x_d = x_q;
    rk_d = rk_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    wrg_d = wrg_q;
    wdata_d = wdata_q;
    done_d = 1'b0;
    fail_d = 1'b0;
    case (st_q)
      SVR_IDLE:
      begin
        if (hit)
        begin
          if (illegal)
          begin
            fail_d = 1'b1;
          end
          else if (start_grp >= len_grp)
          begin
            done_d = 1'b1;
          end
          else
          begin
            grp_d = start_grp;
            end_d = len_grp;
            vs_d = is_vs;
            key_d = is_vs ? 14'h0000 : start_grp;
            rd_d = 1'b1;
            st_d = SVR_LOAD;
          end
        end
      end
      SVR_LOAD:
      begin
        st_d = SVR_CAPT;
      end
      SVR_CAPT:
      begin
        x_d = state_group_i;
        rk_d = key_group_i;
        cnt_d = 2'h0;
        st_d = SVR_ROUND;
      end
      SVR_ROUND:
      begin
        x_d = {new_w, x_q[3], x_q[2], x_q[1]};
        cnt_d = cnt_q + 2'h1;
        if (cnt_q == `SVR_LAST_ROUND)
        begin
          wr_d = 1'b1;
          wrg_d = grp_q;
          wdata_d = {new_w, x_q[3], x_q[2], x_q[1]};
          st_d = SVR_NEXT;
        end
      end
      SVR_NEXT:
      begin
        if ((grp_q + 14'h0001) < end_q)
        begin
          grp_d = grp_q + 14'h0001;
          key_d = vs_q ? 14'h0000 : grp_q + 14'h0001;
          rd_d = 1'b1;
          st_d = SVR_LOAD;
        end
        else
        begin
          done_d = 1'b1;
          st_d = SVR_IDLE;
        end
      end
      default:
      begin
        st_d = SVR_IDLE;
      end
    endcase
    // Busy is registered from the next state so the output leaves a flip-flop.
    busy_d = st_d != SVR_IDLE;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      st_q <= SVR_IDLE;
      grp_q <= 14'h0000;
      end_q <= 14'h0000;
      key_q <= 14'h0000;
      vs_q <= 1'b0;
      cnt_q <= 2'h0;
      x_q <= '0;
      rk_q <= '0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      wrg_q <= 14'h0000;
      wdata_q <= '0;
      done_q <= 1'b0;
      fail_q <= 1'b0;
      busy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      grp_q <= grp_d;
      end_q <= end_d;
      key_q <= key_d;
      vs_q <= vs_d;
      cnt_q <= cnt_d;
      x_q <= x_d;
      rk_q <= rk_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      wrg_q <= wrg_d;
      wdata_q <= wdata_d;
      done_q <= done_d;
      fail_q <= fail_d;
      busy_q <= busy_d;
    end
  end

  assign busy_o = busy_q;
  assign rd_req_o = rd_q;
  assign state_group_o = grp_q;
  assign key_group_o = key_q;
  assign wr_en_o = wr_q;
  assign wr_group_o = wrg_q;
  assign wr_data_o = wdata_q;
  assign done_o = done_q;
  assign fail_o = fail_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence rounds_run_s;
    (st_q == SVR_ROUND) [*4];
  endsequence

  sequence read_to_write_s;
    rd_req_o ##1 (st_q == SVR_CAPT) ##1 rounds_run_s ##1 wr_en_o;
  endsequence

  four_rounds_a: assert property (
    $rose(st_q == SVR_ROUND) |-> rounds_run_s ##1 (wr_en_o && st_q == SVR_NEXT))
    else $error("round phase did not last four cycles");

  read_write_a: assert property (
    rd_req_o |-> read_to_write_s)
    else $error("group read not followed by write after six cycles");

  same_group_a: assert property (
    wr_en_o |-> (wr_group_o == $past(state_group_o, 6)) && $past(rd_req_o, 6))
    else $error("write group differs from the group read");

  scalar_key_a: assert property (
    rd_req_o |-> (key_group_o == (vs_q ? 14'h0000 : state_group_o)))
    else $error("key group does not follow the form");

  key_order_a: assert property (
    $rose(st_q == SVR_ROUND) |-> (cnt_q == 2'h0) ##1 (cnt_q == 2'h1) ##1 (cnt_q == 2'h2)
    ##1 (cnt_q == 2'h3))
    else $error("key words not consumed in order");

  round_mix_a: assert property (
    (st_q == SVR_ROUND) |=> x_q[3] == ($past(x_q[0]) ^ $past(sub_w)
      ^ svr_rol($past(sub_w), `SVR_ROT_A) ^ svr_rol($past(sub_w), `SVR_ROT_B)
      ^ svr_rol($past(sub_w), `SVR_ROT_C) ^ svr_rol($past(sub_w), `SVR_ROT_D)))
    else $error("new state word has wrong linear mix");

  write_order_a: assert property (
    (st_q == SVR_ROUND && cnt_q == 2'h3) |=> (wr_data_o[127:96] == $past(new_w))
      && (wr_data_o[95:0] == $past(x_q[3:1])))
    else $error("written words out of order");

  illegal_fail_a: assert property (
    (st_q == SVR_IDLE && hit && illegal) |=> fail_o && !rd_req_o && st_q == SVR_IDLE)
    else $error("illegal form not refused");

  group_range_a: assert property (
    rd_req_o |-> (state_group_o < end_q))
    else $error("group index beyond length");

  decode_only_a: assert property (
    (st_q == SVR_IDLE && !hit) |=> (st_q == SVR_IDLE) && !fail_o && !done_o)
    else $error("non-matching encoding started work");

endmodule

/* test/svr_pipe_model.sv */
// Behavioural model of the vector register file that feeds the round unit.
`timescale 1ns/10ps

module svr_pipe_model (
  input wire logic clk_i,
  input wire logic rd_req_i,
  input wire logic [13:0] state_group_i,
  input wire logic [13:0] key_group_i,
  input wire logic wr_en_i,
  input wire logic [13:0] wr_group_i,
  input wire logic [127:0] wr_data_i,
  output logic [127:0] state_o,
  output logic [127:0] key_o
);
  logic [127:0] st_mem [8];
  logic [127:0] ky_mem [8];

  initial
  begin
    state_o = 128'h0;
    key_o = 128'h0;
  end

  // Read data stand for one cycle only; after that the lines flip so stale data never match.
  always @(posedge clk_i)
  begin
    if (rd_req_i)
    begin
      state_o <= st_mem[state_group_i[2:0]];
      key_o <= ky_mem[key_group_i[2:0]];
    end
    else
    begin
      state_o <= ~state_o;
      key_o <= ~key_o;
    end
    // A written group becomes the state of the next invocation.
    if (wr_en_i)
    begin
      st_mem[wr_group_i[2:0]] <= wr_data_i;
    end
  end
endmodule

/* test/svr_sm4_round_unit_tb.sv */
// Self-checking bench of the SM4 vector round unit.
`timescale 1ns/10ps
`include "svr_defines.svh"

module svr_sm4_round_unit_tb;
  localparam logic [2047:0] SBOX = {
    128'hd690_e9fe_cce1_3db7_16b6_14c2_28fb_2c05, 128'h2b67_9a76_2abe_04c3_aa44_1326_4986_0699,
    128'h9c42_50f4_91ef_987a_3354_0b43_edcf_ac62, 128'he4b3_1ca9_c908_e895_80df_94fa_758f_3fa6,
    128'h4707_a7fc_f373_17ba_8359_3c19_e685_4fa8, 128'h686b_81b2_7164_da8b_f8eb_0f4b_7056_9d35,
    128'h1e24_0e5e_6358_d1a2_2522_7c3b_0121_7887, 128'hd400_4657_9fd3_2752_4c36_02e7_a0c4_c89e,
    128'heabf_8ad2_40c7_38b5_a3f7_f2ce_f961_15a1, 128'he0ae_5da4_9b34_1a55_ad93_3230_f58c_b1e3,
    128'h1df6_e22e_8266_ca60_c029_23ab_0d53_4e6f, 128'hd5db_3745_defd_8e2f_03ff_6a72_6d6c_5b51,
    128'h8d1b_af92_bbdd_bc7f_11d9_5c41_1f10_5ad8, 128'h0ac1_3188_a5cd_7bbd_2d74_d012_b8e5_b4b0,
    128'h8969_974a_0c96_777e_65b9_f109_c56e_c684, 128'h18f0_7dec_3adc_4d20_79ee_5f3e_d7cb_3948
  };
  logic core_clk, rst, vld;
  logic [6:0] opc, ew;
  logic [2:0] f3, grp_mul;
  logic [5:0] f6;
  logic [4:0] vs1, vd, vs2;
  logic [15:0] vrb, vec_len, st_idx;
  logic [127:0] st_in, ky_in, wr_data_o;
  logic busy_o, rd_req_o, wr_en_o, done_o, fail_o;
  logic [13:0] state_group_o, key_group_o, wr_group_o;
  int num_errors, comparisons, cycles;

  svr_sm4_round_unit DUT (.core_clk_i(core_clk), .rst_i(rst), .instr_valid_i(vld),
    .major_opcode_i(opc), .funct3_i(f3), .funct6_i(f6), .vs1_field_i(vs1), .vd_i(vd),
    .vs2_i(vs2), .register_group_multiplier_i(grp_mul), .vector_register_bits_i(vrb),
    .selected_element_width_i(ew), .vector_length_i(vec_len), .start_index_i(st_idx),
    .state_group_i(st_in), .key_group_i(ky_in), .busy_o(busy_o), .rd_req_o(rd_req_o),
    .state_group_o(state_group_o), .key_group_o(key_group_o), .wr_en_o(wr_en_o),
    .wr_group_o(wr_group_o), .wr_data_o(wr_data_o), .done_o(done_o), .fail_o(fail_o));

  svr_pipe_model mdl (.clk_i(core_clk), .rd_req_i(rd_req_o), .state_group_i(state_group_o),
    .key_group_i(key_group_o), .wr_en_i(wr_en_o), .wr_group_i(wr_group_o),
    .wr_data_i(wr_data_o), .state_o(st_in), .key_o(ky_in));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] rol(input logic [31:0] w, input int n);
    return (w << n) | (w >> (32 - n));
  endfunction

  // Reverses the order of the four words of a group.
  function automatic logic [127:0] wrev(input logic [127:0] x);
    return {x[31:0], x[63:32], x[95:64], x[127:96]};
  endfunction

  // Four chained rounds computed from scratch as the expected write-back.
  function automatic logic [127:0] ref4(input logic [127:0] x, input logic [127:0] k);
    logic [31:0] w [8];
    logic [31:0] b, s;
    for (int i = 0; i < 4; i++) w[i] = x[32*i +: 32];
    for (int r = 0; r < 4; r++)
    begin
      b = w[r+1] ^ w[r+2] ^ w[r+3] ^ k[32*r +: 32];
      for (int j = 0; j < 4; j++) s[8*j +: 8] = SBOX[8*(255 - int'(b[8*j +: 8])) +: 8];
      w[r+4] = w[r] ^ s ^ rol(s, 2) ^ rol(s, 10) ^ rol(s, 18) ^ rol(s, 24);
    end
    return {w[7], w[6], w[5], w[4]};
  endfunction

  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Issues one instruction and follows every read and write until it retires.
  task automatic run(input logic [5:0] f, input logic [4:0] d, input logic [4:0] s2,
      input logic [2:0] gm, input logic [15:0] rb, input logic [6:0] w, input int st,
      input int ln, input logic bad);
    logic [127:0] exp;
    int g, kg, n;
    g = st / 4;
    exp = 128'h0;
    @(posedge core_clk);
    f6 <= f; vd <= d; vs2 <= s2; grp_mul <= gm; vrb <= rb; ew <= w;
    st_idx <= 16'(st); vec_len <= 16'(ln); vld <= 1'b1;
    @(posedge core_clk);
    vld <= 1'b0;
    for (n = 0; n < 100; n++)
    begin
      #1;
      if (rd_req_o)
      begin
        kg = (f == `SVR_FUNCT6_VV) ? g : 0;
        chk(128'(state_group_o), 128'(g));
        chk(128'(key_group_o), 128'(kg));
        exp = ref4(mdl.st_mem[g], mdl.ky_mem[kg]);
      end
      if (wr_en_o)
      begin
        chk(128'(wr_group_o), 128'(g));
        chk(wr_data_o, exp);
        g++;
      end
      if (done_o || fail_o) break;
      @(posedge core_clk);
    end
    chk(128'({fail_o, done_o, busy_o}), 128'({bad, !bad, 1'b0}));
    chk(128'(g), 128'((bad || st >= ln) ? st / 4 : ln / 4));
  endtask

  task automatic t_vv;
    run(`SVR_FUNCT6_VV, 5'h08, 5'h08, 3'h0, 16'h0080, 7'h20, 0, 12, 1'b0);
  endtask

  // Second pass runs on the state written by the first.
  task automatic t_vs;
    run(`SVR_FUNCT6_VS, 5'h00, 5'h08, 3'h0, 16'h0080, 7'h20, 4, 12, 1'b0);
    run(`SVR_FUNCT6_VS, 5'h00, 5'h08, 3'h0, 16'h0080, 7'h20, 4, 12, 1'b0);
  endtask

  task automatic t_bounds;
    run(`SVR_FUNCT6_VV, 5'h00, 5'h08, 3'h6, 16'h0200, 7'h20, 8, 12, 1'b0);
    run(`SVR_FUNCT6_VV, 5'h00, 5'h08, 3'h0, 16'h0080, 7'h20, 8, 8, 1'b0);
  endtask

  task automatic t_illegal;
    run(`SVR_FUNCT6_VV, 5'h00, 5'h08, 3'h5, 16'h0200, 7'h20, 0, 8, 1'b1);
    run(`SVR_FUNCT6_VV, 5'h00, 5'h08, 3'h0, 16'h0080, 7'h10, 0, 8, 1'b1);
    run(`SVR_FUNCT6_VS, 5'h08, 5'h08, 3'h0, 16'h0080, 7'h20, 0, 8, 1'b1);
  endtask

  // Decryption is the same operation run on reversed words with reversed round keys.
  task automatic t_decrypt;
    logic [127:0] plain;
    plain = mdl.st_mem[5];
    run(`SVR_FUNCT6_VV, 5'h08, 5'h08, 3'h0, 16'h0080, 7'h20, 20, 24, 1'b0);
    mdl.st_mem[5] = wrev(mdl.st_mem[5]);
    mdl.ky_mem[5] = wrev(mdl.ky_mem[5]);
    run(`SVR_FUNCT6_VV, 5'h08, 5'h08, 3'h0, 16'h0080, 7'h20, 20, 24, 1'b0);
    chk(mdl.st_mem[5], wrev(plain));
  endtask

  // Neighbouring encodings must leave the unit untouched.
  task automatic t_ignored;
    for (int c = 0; c < 4; c++)
    begin
      @(posedge core_clk);
      f6 <= (c == 1) ? 6'h2a : `SVR_FUNCT6_VV;
      vs1 <= (c == 0) ? 5'h11 : `SVR_VS1_SM4;
      opc <= (c == 2) ? 7'h57 : `SVR_MAJOR_OPC;
      f3 <= (c == 3) ? 3'h1 : `SVR_FUNCT3_MVV;
      vld <= 1'b1;
      @(posedge core_clk);
      vld <= 1'b0;
      repeat (8)
      begin
        #1;
        chk(128'({busy_o, rd_req_o, wr_en_o, done_o, fail_o}), 128'h0);
        @(posedge core_clk);
      end
    end
    vs1 <= `SVR_VS1_SM4;
    opc <= `SVR_MAJOR_OPC;
    f3 <= `SVR_FUNCT3_MVV;
  endtask

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      num_errors++;
      wrap_up;
    end
  end

  initial
  begin
    num_errors = 0; comparisons = 0; cycles = 0;
    rst = 1'b1; vld = 1'b0; opc = `SVR_MAJOR_OPC; f3 = `SVR_FUNCT3_MVV; f6 = 6'h0;
    vs1 = `SVR_VS1_SM4; vd = 5'h0; vs2 = 5'h0; grp_mul = 3'h0; vrb = 16'h0080;
    ew = 7'h20; vec_len = 16'h0; st_idx = 16'h0;
    for (int g = 0; g < 8; g++)
    begin
      mdl.st_mem[g] = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210 ^ {16{8'(g * 37)}};
      mdl.ky_mem[g] = 128'hf00d_1357_2468_ace0_9bdf_0246_8ace_1357 + 128'(g);
    end
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_vv();
    t_vs();
    t_bounds();
    t_illegal();
    t_decrypt();
    t_ignored();
    wrap_up();
  end
endmodule
